// >>> acr_codec_ctrl.sv
// Purpose: control register bank of a six channel audio codec
// Assumes: register writes arrive as a synchronous strobe, core clock is the master clock
// Notes: the bank is write only; its state is visible on the output ports
`timescale 1ns/1ps
module acr_codec_ctrl
	import acr_pkg::*;
(
	// clock and reset
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	// register write port
	input wire logic REG_WR,
	input wire logic [6:0] REG_ADDR,
	input wire logic [8:0] REG_WDATA,
	// frame clock pin
	input wire logic FRAME_CLK_IN,
	output logic FRAME_CLK_OUT,
	output logic FRAME_CLK_OE,
	// bit clock pin
	input wire logic BIT_CLK_IN,
	output logic BIT_CLK_OUT,
	output logic BIT_CLK_OE,
	// clocks seen by the audio core
	output logic AUDIO_FRAME_CLK,
	output logic AUDIO_BIT_CLK,
	// mute pin
	input wire logic MUTE_DIR_INPUT,
	input wire logic MUTE_PIN_IN,
	output logic MUTE_PIN_OUT,
	output logic MUTE_PIN_OE,
	// dac sample zero detection
	input wire logic SAMPLE_STROBE,
	input wire logic [2:0] ZERO_SAMPLE,
	// dac controls
	output logic [47:0] DAC_ATTEN,
	output logic [2:0] SOFT_MUTE,
	// adc controls
	output logic ADC_OSR_64,
	output logic ADC_HPF_BYPASS,
	// status
	output logic MASTER_MODE,
	output logic SW_RESET_HOLD
);

	acr_core_s st_reg;
	acr_core_s st_next;
	acr_clk_if cif ();

	////////////////////////////////////////////////////////////////////////////////
	// decode

	// attenuation channel index; bit 3 flags a valid channel address
	function automatic logic [3:0] chan_of(input logic [6:0] addr);
		unique case (addr)
			`ACR_ADDR_L1: chan_of = 4'h8;
			`ACR_ADDR_R1: chan_of = 4'h9;
			`ACR_ADDR_L2: chan_of = 4'hA;
			`ACR_ADDR_R2: chan_of = 4'hB;
			`ACR_ADDR_L3: chan_of = 4'hC;
			`ACR_ADDR_R3: chan_of = 4'hD;
			default: chan_of = 4'h0;
		endcase
	endfunction : chan_of

	// every register bit back at its default value
	function automatic acr_core_s reg_defaults(input acr_core_s cur);
		acr_core_s d;
		d = cur;
		d.master_sel = `ACR_RST_MS;
		d.ratio = `ACR_RST_RATIO;
		d.osr_sel = `ACR_RST_OSR;
		d.hpf_dis = `ACR_RST_HPD;
		d.mute_dec_dis = `ACR_RST_MPD;
		d.zero_sel = `ACR_RST_ZFS;
		for (int i = 0; i < 6; i++) begin
			d.pend[i] = `ACR_RST_ATTEN;
			d.appl[i] = `ACR_RST_ATTEN;
		end
		return d;
	endfunction : reg_defaults

	////////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		logic [3:0] ch;
		logic upd;
		logic [7:0] val;
		logic [2:0] zflag;
		logic zcond;
		logic pin_level;
		zflag = 3'h0;
		zcond = 1'b0;
		pin_level = 1'b0;
		ch = chan_of(REG_ADDR);
		upd = REG_WDATA[`ACR_BIT_UPDATE];
		val = REG_WDATA[7:0];
		st_next = st_reg;

		// register writes
		if (REG_WR) begin
			if (REG_ADDR == `ACR_ADDR_SWRST) begin
				// reset wins over the release of a pending hold
				st_next = reg_defaults(st_reg);
				st_next.held = 1'b1;
			end else if (st_reg.held) begin
				// releasing write is consumed, nothing stored
				st_next.held = 1'b0;
			end else if (ch[3]) begin
				st_next.pend[ch[2:0]] = val;
				if (upd) begin
					// all channels move together; update bit not kept
					st_next.appl = st_next.pend;
				end
			end else begin
				unique case (REG_ADDR)
					`ACR_ADDR_ALL: begin
						for (int i = 0; i < 6; i++) begin
							st_next.pend[i] = val;
						end
						if (upd) begin
							st_next.appl = st_next.pend;
						end
					end
					`ACR_ADDR_ZERO: begin
						st_next.zero_sel = REG_WDATA[`ACR_ZFS_HI:`ACR_ZFS_LO];
					end
					`ACR_ADDR_IFC: begin
						st_next.master_sel = REG_WDATA[`ACR_BIT_MS];
						st_next.ratio = REG_WDATA[`ACR_RATIO_HI:`ACR_RATIO_LO];
					end
					`ACR_ADDR_OSR: begin
						st_next.osr_sel = REG_WDATA[`ACR_BIT_OSR];
					end
					`ACR_ADDR_ADC: begin
						st_next.hpf_dis = REG_WDATA[`ACR_BIT_HPD];
						st_next.mute_dec_dis = REG_WDATA[`ACR_BIT_MPD];
					end
					default: begin
						// unmapped or out of scope addresses are ignored
					end
				endcase
			end
		end

		// zero run counters, one per stereo pair
		for (int i = 0; i < 3; i++) begin
			if (SAMPLE_STROBE) begin
				if (!ZERO_SAMPLE[i]) begin
					st_next.zero_cnt[i] = 11'h000;
				end else if (st_reg.zero_cnt[i] != `ACR_ZERO_RUN) begin
					st_next.zero_cnt[i] = st_reg.zero_cnt[i] + 11'h001;
				end
			end
		end
		for (int i = 0; i < 3; i++) begin
			zflag[i] = (st_reg.zero_cnt[i] == `ACR_ZERO_RUN);
		end

		// selected zero condition
		if (st_reg.zero_sel == 2'h0) begin
			zcond = &zflag;
		end else begin
			zcond = zflag[st_reg.zero_sel - 2'h1];
		end
		st_next.mute_out = zcond;

		// level on the pin, driven by us or by the outside
		pin_level = MUTE_DIR_INPUT ? MUTE_PIN_IN : st_reg.mute_out;
		if (!pin_level) begin
			st_next.soft_mute = 3'h0;
		end else if (st_reg.mute_dec_dis) begin
			st_next.soft_mute = 3'h7;
		end else if (st_reg.zero_sel == 2'h0) begin
			st_next.soft_mute = 3'h7;
		end else begin
			st_next.soft_mute = 3'h0;
			st_next.soft_mute[st_reg.zero_sel - 2'h1] = 1'b1;
		end

		// clocks used by the audio core
		if (st_reg.master_sel) begin
			st_next.frame_clk_q = cif.frame_clk;
			st_next.bit_clk_q = cif.bit_clk;
		end else begin
			// peer supplies the clocks in slave mode
			st_next.frame_clk_q = FRAME_CLK_IN;
			st_next.bit_clk_q = BIT_CLK_IN;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// state register

	always_ff @(posedge CORE_CLK or negedge RESET_N) begin
		if (!RESET_N) begin
			st_reg.master_sel <= `ACR_RST_MS;
			st_reg.ratio <= `ACR_RST_RATIO;
			st_reg.osr_sel <= `ACR_RST_OSR;
			st_reg.hpf_dis <= `ACR_RST_HPD;
			st_reg.mute_dec_dis <= `ACR_RST_MPD;
			st_reg.zero_sel <= `ACR_RST_ZFS;
			st_reg.pend <= {6{`ACR_RST_ATTEN}};
			st_reg.appl <= {6{`ACR_RST_ATTEN}};
			st_reg.held <= 1'b0;
			st_reg.zero_cnt <= '0;
			st_reg.soft_mute <= 3'h0;
			st_reg.mute_out <= 1'b0;
			st_reg.frame_clk_q <= 1'b0;
			st_reg.bit_clk_q <= 1'b0;
		end else if (CLK_EN) begin
			st_reg <= st_next;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// clock generator

	assign cif.master_sel = st_reg.master_sel;
	assign cif.ratio = st_reg.ratio;

	acr_clkgen u_clkgen (
		.clk(CORE_CLK),
		.reset_n(RESET_N),
		.clk_en(CLK_EN),
		.cif(cif.gen)
	);

	////////////////////////////////////////////////////////////////////////////////
	// outputs

	assign FRAME_CLK_OUT = cif.frame_clk;
	assign BIT_CLK_OUT = cif.bit_clk;
	assign FRAME_CLK_OE = st_reg.master_sel;
	assign BIT_CLK_OE = st_reg.master_sel;
	assign AUDIO_FRAME_CLK = st_reg.frame_clk_q;
	assign AUDIO_BIT_CLK = st_reg.bit_clk_q;

	assign MUTE_PIN_OUT = st_reg.mute_out;
	assign MUTE_PIN_OE = !MUTE_DIR_INPUT;

	// applied codes go to the filter input; 00 mutes, FF is unity
	assign DAC_ATTEN = st_reg.appl;
	// soft mute feeds the filter input so the output fades
	assign SOFT_MUTE = st_reg.soft_mute;

	// 64x only where a 96kHz rate is possible; 128/192/512/768fs leave the adc at 128x
	assign ADC_OSR_64 = st_reg.osr_sel
		&& (st_reg.ratio == 3'h2 || st_reg.ratio == 3'h3);
	assign ADC_HPF_BYPASS = st_reg.hpf_dis;

	assign MASTER_MODE = st_reg.master_sel;
	assign SW_RESET_HOLD = st_reg.held;

endmodule : acr_codec_ctrl

// >>> acr_map.svh
// Purpose: addresses, field positions, reset values and counts of the codec control bank
// Assumes: 7-bit register address, 9-bit write data, master clock is the core clock
// Notes: definitions only
//
// Notes on behaviour
// - master_select 1 drives frame and bit clocks
// - master clocks derived from master clock ratio
// - ratio codes 128/192/256/384/512/768fs, default 256fs
// - 128fs and 192fs serve the DAC only
// - adc_oversample_select picks 64x, else 128x
// - 64x only at 256fs or 384fs ratio
// - adc_highpass_disable bypasses the ADC highpass
// - decoded input mute hits the selected channel
// - mute pin output shows selected zero condition
// - channel 1 zero run softmutes channel 1
// - decode disabled: pin high mutes all channels
// - six 8-bit attenuations, reset FF = 0dB
// - code 00 mute, 01 -127dB, FF 0dB
// - update bit clear only loads intermediate latch
// - update bit set applies all latches together
// - master attenuation write loads all channels
// - write to 1F restores all register defaults
// - after soft reset, hold until next write
// - zero select 00 all, 01..11 one channel
// - soft mute acts on filter input, fading
`ifndef ACR_MAP_SVH
`define ACR_MAP_SVH

`define ACR_ADDR_L1 7'h00
`define ACR_ADDR_R1 7'h01
`define ACR_ADDR_L2 7'h04
`define ACR_ADDR_R2 7'h05
`define ACR_ADDR_L3 7'h06
`define ACR_ADDR_R3 7'h07
`define ACR_ADDR_ALL 7'h08
`define ACR_ADDR_ZERO 7'h09
`define ACR_ADDR_IFC 7'h0A
`define ACR_ADDR_OSR 7'h0B
`define ACR_ADDR_ADC 7'h0C
`define ACR_ADDR_SWRST 7'h1F

`define ACR_BIT_UPDATE 8
`define ACR_BIT_MS 5
`define ACR_RATIO_HI 8
`define ACR_RATIO_LO 6
`define ACR_BIT_OSR 8
`define ACR_BIT_HPD 3
`define ACR_BIT_MPD 6
`define ACR_ZFS_HI 2
`define ACR_ZFS_LO 1

`define ACR_RST_ATTEN 8'hFF
`define ACR_RST_RATIO 3'h2
`define ACR_RST_MS 1'h0
`define ACR_RST_OSR 1'h0
`define ACR_RST_HPD 1'h0
`define ACR_RST_MPD 1'h0
`define ACR_RST_ZFS 2'h0

`define ACR_ZERO_RUN 11'h400
`define ACR_BITS_PER_FRAME 64

`endif

// >>> acr_pkg.sv
// Purpose: types and clock ratio arithmetic of the codec control bank
// Assumes: acr_map.svh included here
// Notes: ratio codes 110 and 111 fall back to 256fs
package acr_pkg;
	`include "acr_map.svh"

	typedef logic [2:0] acr_ratio_t;
	typedef logic [7:0] acr_atten_t;

	typedef enum logic [2:0] {
		ACR_R128, ACR_R192, ACR_R256, ACR_R384, ACR_R512, ACR_R768
	} acr_ratio_e;

	// master clocks per frame for a ratio code
	function automatic logic [9:0] acr_frame_len(input acr_ratio_t code);
		unique case (code)
			3'h0: acr_frame_len = 10'h080;
			3'h1: acr_frame_len = 10'h0C0;
			3'h3: acr_frame_len = 10'h180;
			3'h4: acr_frame_len = 10'h200;
			3'h5: acr_frame_len = 10'h300;
			default: acr_frame_len = 10'h100;
		endcase
	endfunction : acr_frame_len

	// master clocks per bit clock period
	function automatic logic [3:0] acr_bit_div(input acr_ratio_t code);
		logic [9:0] len;
		len = acr_frame_len(code);
		acr_bit_div = len[9:6];
	endfunction : acr_bit_div

	typedef struct packed {
		logic [9:0] frame_cnt;
		logic [3:0] bit_cnt;
		acr_ratio_t ratio_act;
		logic frame_clk;
		logic bit_clk;
	} acr_gen_s;

	typedef struct packed {
		logic master_sel;
		acr_ratio_t ratio;
		logic osr_sel;
		logic hpf_dis;
		logic mute_dec_dis;
		logic [1:0] zero_sel;
		logic [5:0][7:0] pend;
		logic [5:0][7:0] appl;
		logic held;
		logic [2:0][10:0] zero_cnt;
		logic [2:0] soft_mute;
		logic mute_out;
		logic frame_clk_q;
		logic bit_clk_q;
	} acr_core_s;
endpackage : acr_pkg

// >>> acr_clk_if.sv
// Purpose: carries mode, ratio and generated clocks between control and generator
// Assumes: one clock domain
// Notes: generated clocks are registered in the generator
`timescale 1ns/1ps
interface acr_clk_if;
	import acr_pkg::*;
	logic master_sel;
	acr_ratio_t ratio;
	logic frame_clk;
	logic bit_clk;

	modport ctrl (output master_sel, output ratio, input frame_clk, input bit_clk);
	modport gen (input master_sel, input ratio, output frame_clk, output bit_clk);
endinterface : acr_clk_if

// >>> acr_clkgen.sv
// Purpose: master mode frame and bit clock generator
// Assumes: core clock is the master clock, 64 bit clocks per frame
// Notes: ratio is sampled at the frame boundary in master mode and every cycle while slave
`timescale 1ns/1ps
module acr_clkgen
	import acr_pkg::*;
(
	// clock and reset
	input wire logic clk,
	input wire logic reset_n,
	input wire logic clk_en,
	// mode and clocks
	acr_clk_if.gen cif
);

	acr_gen_s st_reg;
	acr_gen_s st_next;

	////////////////////////////////////////////////////////////////////////////////
	always_comb begin
		logic [9:0] len;
		logic [3:0] div;
		len = acr_frame_len(st_reg.ratio_act);
		div = acr_bit_div(st_reg.ratio_act);
		st_next = st_reg;
		if (!cif.master_sel) begin
			// slave: idle, counters cleared; the first master frame runs one cycle short
			st_next.frame_cnt = 10'h000;
			st_next.bit_cnt = 4'h0;
			st_next.ratio_act = cif.ratio;
			st_next.frame_clk = 1'b0;
			st_next.bit_clk = 1'b0;
		end else begin
			if (st_reg.frame_cnt == len - 10'h001) begin
				// frame boundary: no truncated pulses
				st_next.frame_cnt = 10'h000;
				st_next.bit_cnt = 4'h0;
				st_next.ratio_act = cif.ratio;
			end else begin
				st_next.frame_cnt = st_reg.frame_cnt + 10'h001;
				st_next.bit_cnt = (st_reg.bit_cnt == div - 4'h1) ? 4'h0 : st_reg.bit_cnt + 4'h1;
			end
			st_next.frame_clk = (st_next.frame_cnt < {1'b0, len[9:1]});
			st_next.bit_clk = (st_next.bit_cnt < {1'b0, div[3:1]});
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			st_reg <= '{frame_cnt: 10'h000, bit_cnt: 4'h0, ratio_act: `ACR_RST_RATIO,
				frame_clk: 1'b0, bit_clk: 1'b0};
		end else if (clk_en) begin
			st_reg <= st_next;
		end
	end

	assign cif.frame_clk = st_reg.frame_clk;
	assign cif.bit_clk = st_reg.bit_clk;

endmodule : acr_clkgen

// >>> acr_codec_ctrl_chk.sv
// Purpose: port checks of the codec control bank
// Assumes: one master clock domain
// Notes: bound below
`timescale 1ns/1ps
module acr_codec_ctrl_chk (
	// clock and writes
	input wire logic CORE_CLK,
	input wire logic RESET_N,
	input wire logic CLK_EN,
	input wire logic REG_WR,
	input wire logic [6:0] REG_ADDR,
	input wire logic [8:0] REG_WDATA,
	// clock pins
	input wire logic FRAME_CLK_IN,
	input wire logic FRAME_CLK_OUT,
	input wire logic FRAME_CLK_OE,
	input wire logic BIT_CLK_IN,
	input wire logic BIT_CLK_OE,
	input wire logic AUDIO_FRAME_CLK,
	input wire logic AUDIO_BIT_CLK,
	// mute and controls
	input wire logic MUTE_DIR_INPUT,
	input wire logic MUTE_PIN_OE,
	input wire logic [47:0] DAC_ATTEN,
	input wire logic ADC_OSR_64,
	input wire logic ADC_HPF_BYPASS,
	input wire logic MASTER_MODE,
	input wire logic SW_RESET_HOLD
);
	default clocking @(posedge CORE_CLK); endclocking
	default disable iff (!RESET_N);
	logic wr;
	// held writes other than to 1F only release, so they are kept out
	assign wr = REG_WR && CLK_EN && !SW_RESET_HOLD;
	a_oe_mode: assert property (FRAME_CLK_OE == MASTER_MODE && BIT_CLK_OE == MASTER_MODE)
		else $error("pin enable differs from mode");
	a_ms_write: assert property (wr && REG_ADDR == 7'h0A |=> MASTER_MODE == $past(REG_WDATA[5]))
		else $error("mode bit not taken");
	a_slave_clk: assert property (CLK_EN && !MASTER_MODE |=>
		AUDIO_FRAME_CLK == $past(FRAME_CLK_IN) && AUDIO_BIT_CLK == $past(BIT_CLK_IN))
		else $error("peer clocks not passed");
	a_frame_high: assert property ($rose(FRAME_CLK_OUT) |-> (FRAME_CLK_OUT || !MASTER_MODE) [*8])
		else $error("frame clock pulse truncated");
	a_osr_clear: assert property (wr && REG_ADDR == 7'h0B && !REG_WDATA[8] |=> !ADC_OSR_64)
		else $error("oversample not cleared");
	a_hpf_write: assert property (wr && REG_ADDR == 7'h0C |=> ADC_HPF_BYPASS == $past(REG_WDATA[3]))
		else $error("highpass bit not taken");
	a_mute_oe: assert property (MUTE_PIN_OE == !MUTE_DIR_INPUT)
		else $error("mute pin enable wrong");
	a_atten_hold: assert property (wr && REG_ADDR != 7'h1F &&
		!(REG_WDATA[8] && REG_ADDR inside {7'h00, 7'h01, [7'h04:7'h08]}) |=> $stable(DAC_ATTEN))
		else $error("applied attenuation moved");
	a_atten_upd: assert property (wr && REG_ADDR == 7'h00 && REG_WDATA[8] |=>
		DAC_ATTEN[7:0] == $past(REG_WDATA[7:0]))
		else $error("update not applied");
	a_master_all: assert property (wr && REG_ADDR == 7'h08 && REG_WDATA[8] |=>
		DAC_ATTEN == {6{$past(REG_WDATA[7:0])}})
		else $error("master value not on all");
	a_swrst_hold: assert property (REG_WR && CLK_EN && REG_ADDR == 7'h1F |=>
		SW_RESET_HOLD && !MASTER_MODE && DAC_ATTEN == {6{8'hFF}})
		else $error("soft reset not taken");
	a_hold_release: assert property (REG_WR && CLK_EN && SW_RESET_HOLD && REG_ADDR != 7'h1F |=>
		!SW_RESET_HOLD && $stable(ADC_HPF_BYPASS))
		else $error("hold release wrong");
endmodule : acr_codec_ctrl_chk
bind acr_codec_ctrl acr_codec_ctrl_chk acr_codec_ctrl_chk_i (.*);

// >>> acr_peer.sv
// Purpose: audio interface peer supplying slave clocks
// Assumes: runs off the master clock
// Notes: 256 cycle frame, 4 cycle bit clock
`timescale 1ns/1ps
module acr_peer (
	// clock and control
	input wire logic clk,
	input wire logic run,
	// clocks toward the device
	output logic frame_clk,
	output logic bit_clk
);
	logic [7:0] cnt = 8'h00;
	initial frame_clk = 1'b0;
	initial bit_clk = 1'b0;
	// idle low outside a run, no stale edges reach the core
	always @(posedge clk) begin
		cnt <= run ? cnt + 8'h01 : 8'h00;
		frame_clk <= run & cnt[7];
		bit_clk <= run & cnt[1];
	end
endmodule : acr_peer

// >>> acr_codec_ctrl_bench.sv
// Purpose: self-checking bench of the codec control bank
// Assumes: clock enable held high
// Notes: expected notes queued, compared by a monitor
`timescale 1ns/1ps
module acr_codec_ctrl_bench;
	import acr_pkg::*;
`define CHK(n, e, a) begin checked++; if ((a) !== (e)) begin num_errors++; \
	$display("unexpected %s expected %h seen %h", n, e, a); end end
	logic CORE_CLK = 1'b0, RESET_N = 1'b0, REG_WR = 1'b0, look = 1'b0, fr_q = 1'b0, bc_q = 1'b0;
	logic MUTE_DIR_INPUT = 1'b0, MUTE_PIN_IN = 1'b0, SAMPLE_STROBE = 1'b0, peer_run = 1'b0;
	logic [6:0] REG_ADDR = 7'h00;
	logic [8:0] REG_WDATA = 9'h000;
	logic [2:0] ZERO_SAMPLE = 3'h0;
	logic FRAME_CLK_IN, BIT_CLK_IN, FRAME_CLK_OUT, FRAME_CLK_OE, BIT_CLK_OUT, BIT_CLK_OE;
	logic AUDIO_FRAME_CLK, AUDIO_BIT_CLK, MUTE_PIN_OUT, MUTE_PIN_OE, ADC_OSR_64;
	logic ADC_HPF_BYPASS, MASTER_MODE, SW_RESET_HOLD;
	logic [47:0] DAC_ATTEN;
	logic [2:0] SOFT_MUTE;
	int num_errors = 0, checked = 0, seed = 32'h3B31, fr_cnt = 0, fr_per = 0, bc_cnt = 0, bc_per = 0;
	typedef struct {string name; int sel; logic [47:0] exp;} acr_note_s;
	acr_note_s notes[$];
	acr_codec_ctrl acr_codec_ctrl_i (.CLK_EN(1'b1), .*);
	acr_peer acr_peer_i (.clk(CORE_CLK), .run(peer_run), .frame_clk(FRAME_CLK_IN), .bit_clk(BIT_CLK_IN));
	initial begin
		forever #2 CORE_CLK = ~CORE_CLK;
	end
	////////////////////////////////////////////////////////////////////////////////
	function automatic logic [47:0] obs(input int sel);
		case (sel)
			0: obs = DAC_ATTEN;
			1: obs = {MASTER_MODE, FRAME_CLK_OE, BIT_CLK_OE};
			2: obs = {ADC_OSR_64, ADC_HPF_BYPASS};
			3: obs = SW_RESET_HOLD;
			4: obs = {MUTE_PIN_OUT, SOFT_MUTE};
			5: obs = 48'(fr_per);
			default: obs = 48'(bc_per);
		endcase
	endfunction : obs
	always @(posedge CORE_CLK) begin
		acr_note_s n;
		fr_cnt++;
		bc_cnt++;
		if (FRAME_CLK_OUT && !fr_q) begin
			fr_per = fr_cnt;
			fr_cnt = 0;
		end
		if (BIT_CLK_OUT && !bc_q) begin
			bc_per = bc_cnt;
			bc_cnt = 0;
		end
		fr_q = FRAME_CLK_OUT;
		bc_q = BIT_CLK_OUT;
		if (look) begin
			n = notes.pop_front();
			`CHK(n.name, n.exp, obs(n.sel))
		end
	end
	////////////////////////////////////////////////////////////////////////////////
	task automatic wr(input logic [6:0] a, input logic [8:0] d);
		@(negedge CORE_CLK);
		REG_WR = 1'b1;
		REG_ADDR = a;
		REG_WDATA = d;
		@(negedge CORE_CLK);
		REG_WR = 1'b0;
	endtask : wr
	task automatic note(input string s, input int sel, input logic [47:0] e);
		notes.push_back('{s, sel, e});
		@(negedge CORE_CLK);
		look = 1'b1;
		@(negedge CORE_CLK);
		look = 1'b0;
	endtask : note
	task automatic strobe(input int k, input logic [2:0] z);
		repeat (k) begin
			@(negedge CORE_CLK);
			SAMPLE_STROBE = 1'b1;
			ZERO_SAMPLE = z;
			@(negedge CORE_CLK);
			SAMPLE_STROBE = 1'b0;
		end
	endtask : strobe
	task automatic test_done;
		$display("checks %0d errors %0d", checked, num_errors);
		if (num_errors == 0 && checked > 0) $display("ALL CHECKS OK");
		else $display("CHECKS NOT OK");
		$finish;
	endtask : test_done
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		logic [7:0] v [6];
		logic [6:0] adr [6] = '{7'h00, 7'h01, 7'h04, 7'h05, 7'h06, 7'h07};
		logic [7:0] codes [4] = '{8'h00, 8'h01, 8'hFE, 8'hFF};
		int len [6] = '{128, 192, 256, 384, 512, 768};
		repeat (3) @(negedge CORE_CLK);
		RESET_N = 1'b1;
		note("reset atten", 0, {6{8'hFF}});
		note("reset mode", 1, 48'h0);
		note("reset adc", 2, 48'h0);
		for (int i = 0; i < 6; i++) begin
			v[i] = 8'($random(seed));
			wr(adr[i], {1'b0, v[i]});
		end
		note("no update", 0, {6{8'hFF}});
		foreach (codes[j]) begin
			wr(7'h00, {1'b1, codes[j]});
			note("update all", 0, {v[5], v[4], v[3], v[2], v[1], codes[j]});
		end
		v[0] = 8'($random(seed));
		wr(7'h08, {1'b0, v[0]});
		wr(7'h02, 9'h1AA);
		note("unmapped", 0, {v[5], v[4], v[3], v[2], v[1], 8'hFF});
		wr(7'h01, 9'h133);
		note("master applied", 0, {{4{v[0]}}, 8'h33, v[0]});
		wr(7'h08, 9'h1FF);
		note("all 0 dB", 0, {6{8'hFF}});
		peer_run = 1'b1;
		for (int r = 0; r < 6; r++) begin
			wr(7'h0A, 9'(r << 6));
			wr(7'h0B, 9'h100);
			note("oversample", 2, (r == 2 || r == 3) ? 48'h2 : 48'h0);
		end
		wr(7'h0B, 9'h000);
		wr(7'h0C, 9'h008);
		note("highpass", 2, 48'h1);
		peer_run = 1'b0;
		// generator copies the ratio while slave; preload the first one
		wr(7'h0A, 9'h000);
		// rising ratios keep each wait over one old plus two new frames
		for (int r = 0; r < 6; r++) begin
			wr(7'h0A, 9'(r << 6) | 9'h020);
			repeat (3 * len[r]) @(negedge CORE_CLK);
			note("frame period", 5, 48'(len[r]));
			note("bit period", 6, 48'(len[r] / 64));
		end
		note("master mode", 1, 48'h7);
		wr(7'h09, 9'h002);
		strobe(1023, 3'h1);
		note("short run", 4, 48'h0);
		strobe(1, 3'h1);
		repeat (2) @(negedge CORE_CLK);
		note("zero flag", 4, 48'h9);
		MUTE_DIR_INPUT = 1'b1;
		MUTE_PIN_IN = 1'b1;
		wr(7'h09, 9'h004);
		note("pin mute pair", 4, 48'h2);
		wr(7'h0C, 9'h040);
		note("pin mute all", 4, 48'h7);
		MUTE_PIN_IN = 1'b0;
		wr(7'h1F, 9'h000);
		note("held", 3, 48'h1);
		note("defaults", 0, {6{8'hFF}});
		note("mode default", 1, 48'h0);
		wr(7'h0C, 9'h008);
		note("release", 3, 48'h0);
		note("not stored", 2, 48'h0);
		wr(7'h0C, 9'h008);
		note("stored", 2, 48'h1);
		test_done();
	end
	initial begin
		#200000;
		num_errors++;
		test_done();
	end
endmodule : acr_codec_ctrl_bench
